//--- include/cbi_pkg.sv
// Shared constants for the clock buffer serial configuration slave
`default_nettype none
package cbi_pkg;
    localparam logic [5:0] SLAVE_ADDR_HI = 6'h36;       // Fixed upper six address bits 110110
    localparam logic [7:0] REG_OUT_REQ_POL = 8'h00;     // output_request_and_polarity
    localparam logic [7:0] REG_MREQ_DECODE = 8'h01;     // master_request_decode_and_type
    localparam logic [7:0] RST_OUT_REQ_POL = 8'h9F;     // Outputs 4,1 on; all polarities high
    localparam logic [7:0] RST_MREQ_DECODE = 8'hF0;     // All requests in decode, wired-OR
    localparam logic [7:0] MREQ_WRITE_MASK = 8'hFC;     // Reserved bits 1:0 stay zero
    localparam logic [7:0] RESET_PIN_SET = 8'h90;       // Internal requests 4 and 1 forced on
    localparam int REQ_INT_LSB = 4;                     // Internal request field low bit
    localparam int MDEC_LSB = 4;                        // Decode include field low bit
    localparam int MTYPE_HI = 3;                        // Master request type high bit
    localparam int MTYPE_LO = 2;                        // Master request type low bit
    localparam int BITS_PER_BYTE = 8;                   // Serial byte length
    typedef enum logic [7:0] {
        ST_IDLE = 8'h01,
        ST_ADDR = 8'h02,
        ST_AACK = 8'h04,
        ST_WDAT = 8'h08,
        ST_WACK = 8'h10,
        ST_RDAT = 8'h20,
        ST_RACK = 8'h40,
        ST_SKIP = 8'h80
    } cbi_state_type;
endpackage
`default_nettype wire

//--- include/cbi_line_if.sv
// Interface carrying synchronised bus lines and their detected events
`default_nettype none
interface cbi_line_if;
    logic sclRise;
    logic sclFall;
    logic sdaLevel;
    logic startSeen;
    logic stopSeen;
    modport src (output sclRise, output sclFall, output sdaLevel, output startSeen, output stopSeen);
    modport dst (input sclRise, input sclFall, input sdaLevel, input startSeen, input stopSeen);
endinterface
`default_nettype wire

//--- src/cbi_line_sync.sv
// Two-stage synchronisers and edge / start / stop detection for the bus lines
`default_nettype none
module cbi_line_sync (
    input wire logic core_clk,  // System clock
    input wire logic rst_b,     // Asynchronous reset, active low
    input wire logic sclIn,     // Raw serial clock pin
    input wire logic sdaIn,     // Raw serial data pin
    cbi_line_if.src lines       // Detected events
);
    logic [1:0] sclMeta_r;
    logic [1:0] sdaMeta_r;
    logic sclOld_r;
    logic sdaOld_r;

    // Synchronisers; the first stage feeds only the second
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            sclMeta_r <= 2'h3;
            sdaMeta_r <= 2'h3;
        end else begin
            sclMeta_r <= {sclMeta_r[0], sclIn};
            sdaMeta_r <= {sdaMeta_r[0], sdaIn};
        end
    end

    // Previous settled levels for edge detection
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            sclOld_r <= 1'h1;
            sdaOld_r <= 1'h1;
        end else begin
            sclOld_r <= sclMeta_r[1];
            sdaOld_r <= sdaMeta_r[1];
        end
    end

    // Both lines delayed equally, so start/stop is judged on matched samples
    assign lines.sclRise = sclMeta_r[1] & ~sclOld_r;
    assign lines.sclFall = ~sclMeta_r[1] & sclOld_r;
    assign lines.sdaLevel = sdaMeta_r[1];
    assign lines.startSeen = sclMeta_r[1] & sclOld_r & sdaOld_r & ~sdaMeta_r[1];
    assign lines.stopSeen = sclMeta_r[1] & sclOld_r & ~sdaOld_r & sdaMeta_r[1];
endmodule
`default_nettype wire

//--- src/cbi_config_slave.sv
// Serial configuration slave with the request and decode registers
// Functional notes
// - Slave on two-wire bus, 7-bit addressing, high-speed mode up to 3.4 Mbit/s.
// - Works with fast and standard mode masters in both directions.
// - Only single-byte writes and reads; no command byte, no blocks.
// - A written byte lands in its register and acts at once.
// - Address bits 6..1 are 110110; bit 0 comes from the select pin.
// - Register 00h bits 7..4 switch outputs 4..1; default 4 and 1 on.
// - Reset pin sets internal requests 1 and 4; other bits unchanged.
// - Register 00h bits 3..0 give request polarity; 1 is active-high, default.
// - Register 01h bits 7..4 include requests in master decode; default included.
// - Register 01h bits 3:2 pick master pin style: OR, AND, push-pull.
// - Internal request ignored while its priority bit is low.
// - Bits not affected by reset pin hold through it.
// - Defaults return only on digital supply power-up.
// - Bytes move most significant bit first.
`default_nettype none
module cbi_config_slave #(
    parameter int NUM_REGS = 2  // Implemented register count
) (
    input wire logic core_clk,                  // System clock
    input wire logic rst_b,                     // Power-up reset, active low
    input wire logic resetPin_b,                // Device reset pin, active low
    input wire logic sclIn,                     // Serial clock pin
    input wire logic sdaIn,                     // Serial data pin input
    output logic sdaOut,                        // Serial data output level
    output logic sdaOe,                         // Serial data drive enable
    input wire logic address_select_pin,        // Address bit 0 select
    input wire logic [3:0] request_priority_bit, // Per-output priority bits
    output logic [3:0] outputInternalRequest,   // Effective internal requests 4..1
    output logic [3:0] requestPolarity,         // Polarity of requests 4..1
    output logic [3:0] requestInMasterDecode,   // Decode inclusion 4..1
    output logic master_request_type_hi,        // Master pin style high bit
    output logic master_request_type_lo         // Master pin style low bit
);
    // Configuration storage, pin synchronisers and bus engine state
    logic [7:0] regOutReqPol_r;
    logic [7:0] regMreq_r;
    logic [1:0] rstPinMeta_r;
    logic [1:0] addrSelMeta_r;
    logic [7:0] shift_r;
    logic [3:0] bitCnt_r;
    logic readMode_r;
    logic [7:0] regPtr_r;
    logic sdaOe_r;
    // Read data seen by the engine and the write strobe to the registers
    logic [7:0] rdData;
    logic writeDone;
    cbi_pkg::cbi_state_type state_r;
    cbi_line_if lines ();

    cbi_line_sync uSync (
        .core_clk(core_clk),
        .rst_b(rst_b),
        .sclIn(sclIn),
        .sdaIn(sdaIn),
        .lines(lines)
    );

    // Register select from the pointer, which always holds register 00h
    function automatic logic regHit(input logic [7:0] ptr, input logic [7:0] off);
        regHit = (ptr == off);
    endfunction

    // Pin synchronisers for reset pin and address select
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            rstPinMeta_r <= 2'h3;
            addrSelMeta_r <= 2'h0;
        end else begin
            rstPinMeta_r <= {rstPinMeta_r[0], resetPin_b};
            addrSelMeta_r <= {addrSelMeta_r[0], address_select_pin};
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Serial protocol engine; sampled on the core clock, so any bus rate up to
    // high-speed works as long as each clock phase spans a few core cycles
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            state_r <= cbi_pkg::ST_IDLE;
            shift_r <= 8'h00;
            bitCnt_r <= 4'h0;
            readMode_r <= 1'h0;
            sdaOe_r <= 1'h0;
        end else if (lines.stopSeen) begin
            state_r <= cbi_pkg::ST_IDLE;
            sdaOe_r <= 1'h0;
        end else if (lines.startSeen) begin
            state_r <= cbi_pkg::ST_ADDR;
            bitCnt_r <= 4'h0;
            sdaOe_r <= 1'h0;
        end else begin
            case (state_r)
                cbi_pkg::ST_ADDR: begin
                    if (lines.sclRise) begin
                        shift_r <= {shift_r[6:0], lines.sdaLevel};
                        bitCnt_r <= bitCnt_r + 4'h1;
                    end else if (lines.sclFall && bitCnt_r == 4'(cbi_pkg::BITS_PER_BYTE)) begin
                        bitCnt_r <= 4'h0;
                        if (shift_r[7:2] == cbi_pkg::SLAVE_ADDR_HI && shift_r[1] == addrSelMeta_r[1]) begin
                            readMode_r <= shift_r[0];
                            sdaOe_r <= 1'h1;
                            state_r <= cbi_pkg::ST_AACK;
                        end else begin
                            state_r <= cbi_pkg::ST_SKIP;
                        end
                    end
                end
                cbi_pkg::ST_AACK: begin
                    if (lines.sclFall) begin
                        if (readMode_r) begin
                            // First data bit goes out as the ack is released
                            shift_r <= rdData;
                            sdaOe_r <= ~rdData[7];
                            bitCnt_r <= 4'h1;
                            state_r <= cbi_pkg::ST_RDAT;
                        end else begin
                            sdaOe_r <= 1'h0;
                            state_r <= cbi_pkg::ST_WDAT;
                        end
                    end
                end
                cbi_pkg::ST_WDAT: begin
                    if (lines.sclRise) begin
                        shift_r <= {shift_r[6:0], lines.sdaLevel};
                        bitCnt_r <= bitCnt_r + 4'h1;
                    end else if (lines.sclFall && bitCnt_r == 4'(cbi_pkg::BITS_PER_BYTE)) begin
                        sdaOe_r <= 1'h1;
                        state_r <= cbi_pkg::ST_WACK;
                    end
                end
                cbi_pkg::ST_WACK: begin
                    // Ack slot ends; any further byte is left unanswered
                    if (lines.sclFall) begin
                        sdaOe_r <= 1'h0;
                        state_r <= cbi_pkg::ST_SKIP;
                    end
                end
                cbi_pkg::ST_RDAT: begin
                    if (lines.sclFall) begin
                        if (bitCnt_r == 4'(cbi_pkg::BITS_PER_BYTE)) begin
                            sdaOe_r <= 1'h0;
                            state_r <= cbi_pkg::ST_RACK;
                        end else begin
                            shift_r <= {shift_r[6:0], 1'h0};
                            sdaOe_r <= ~shift_r[6];
                            bitCnt_r <= bitCnt_r + 4'h1;
                        end
                    end
                end
                cbi_pkg::ST_RACK: begin
                    if (lines.sclFall) begin
                        state_r <= cbi_pkg::ST_SKIP;
                    end
                end
                cbi_pkg::ST_SKIP: begin
                    // Foreign address or surplus byte: stay off the line until the next stop or start
                    sdaOe_r <= 1'h0;
                end
                default: begin
                    state_r <= cbi_pkg::ST_IDLE;
                end
            endcase
        end
    end

    // Register pointer; no command byte, so the first register is always used
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            regPtr_r <= cbi_pkg::REG_OUT_REQ_POL;
        end else begin
            regPtr_r <= cbi_pkg::REG_OUT_REQ_POL;
        end
    end

    // Read mux; unknown pointer values read zero
    always_comb begin
        rdData = 8'h00;
        if (regHit(regPtr_r, cbi_pkg::REG_OUT_REQ_POL)) begin
            rdData = regOutReqPol_r;
        end else if (regHit(regPtr_r, cbi_pkg::REG_MREQ_DECODE) && NUM_REGS > 1) begin
            rdData = regMreq_r & cbi_pkg::MREQ_WRITE_MASK;
        end
    end

    // Strobe at the end of the data byte's ack slot; the shift register still holds the byte
    assign writeDone = (state_r == cbi_pkg::ST_WACK) && lines.sclFall;

    ////////////////////////////////////////////////////////////////////////////
    // Configuration registers; only power-up reset restores defaults
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            regOutReqPol_r <= cbi_pkg::RST_OUT_REQ_POL;
        end else if (!rstPinMeta_r[1]) begin
            regOutReqPol_r <= regOutReqPol_r | cbi_pkg::RESET_PIN_SET;
        end else if (writeDone && regHit(regPtr_r, cbi_pkg::REG_OUT_REQ_POL)) begin
            regOutReqPol_r <= shift_r;
        end
    end

    // Decode register holds across the reset pin entirely
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            regMreq_r <= cbi_pkg::RST_MREQ_DECODE;
        end else if (writeDone && regHit(regPtr_r, cbi_pkg::REG_MREQ_DECODE)) begin
            regMreq_r <= shift_r & cbi_pkg::MREQ_WRITE_MASK;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Outputs; open-drain data line only ever pulls low
    assign sdaOut = 1'h0;
    assign sdaOe = sdaOe_r;
    assign outputInternalRequest = regOutReqPol_r[cbi_pkg::REQ_INT_LSB +: 4] & request_priority_bit;
    assign requestPolarity = regOutReqPol_r[3:0];
    assign requestInMasterDecode = regMreq_r[cbi_pkg::MDEC_LSB +: 4];
    assign master_request_type_hi = regMreq_r[cbi_pkg::MTYPE_HI];
    assign master_request_type_lo = regMreq_r[cbi_pkg::MTYPE_LO];
endmodule
`default_nettype wire

//--- bench/cbi_i2c_master.sv
// Behavioural bus master that drives the serial clock and data lines
`default_nettype none
module cbi_i2c_master (
    output logic scl,    // Serial clock, stands high between frames
    output logic sdaLow, // High while the master pulls data low
    input wire logic sda // Resolved data line
);
    timeunit 1ns;
    timeprecision 100ps;
    localparam int Q = 12; // Quarter of a 48 ns bus period
    // Idle bus: both lines released
    initial begin
        scl = 1'b1;
        sdaLow = 1'b0;
    end
    // Start from an idle bus only; no repeated start here
    // Line changes are nonblocking: one that falls on a core edge lands after the synchronisers sample
    task automatic start();
        #(2*Q);
        sdaLow <= 1'b1;
        #(2*Q);
        scl <= 1'b0;
    endtask
    // One byte plus the ack slot; data moves only while clock is low
    task automatic xfer(input logic [7:0] tx, output logic [7:0] rx, output logic ack);
        for (int i = 7; i >= -1; i--) begin
            #Q;
            sdaLow <= (i >= 0) ? ~tx[i] : 1'b0;
            #Q;
            scl <= 1'b1;
            #Q;
            if (i >= 0) rx[i] = sda;
            else ack = ~sda;
            #Q;
            scl <= 1'b0;
        end
    endtask
    // Stop, then leave the clock standing high
    task automatic stop();
        #Q;
        sdaLow <= 1'b1;
        #Q;
        scl <= 1'b1;
        #(2*Q);
        sdaLow <= 1'b0;
        #(2*Q);
    endtask
endmodule
`default_nettype wire

//--- bench/cbi_config_slave_sva.sv
// Assertions on the serial configuration slave ports
`default_nettype none
module cbi_config_slave_sva (
    input wire logic core_clk,                   // Clock
    input wire logic rst_b,                      // Power-up reset
    input wire logic resetPin_b,                 // Reset pin
    input wire logic sclIn,                      // Bus clock
    input wire logic sdaIn,                      // Bus data
    input wire logic sdaOut,                     // Data level
    input wire logic sdaOe,                      // Data drive
    input wire logic address_select_pin,         // Address bit 0
    input wire logic [3:0] request_priority_bit, // Priorities
    input wire logic [3:0] outputInternalRequest, // Requests
    input wire logic [3:0] requestPolarity,      // Polarities
    input wire logic [3:0] requestInMasterDecode, // Decode
    input wire logic master_request_type_hi,     // Type high
    input wire logic master_request_type_lo      // Type low
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_b);
    // Drive changes only shortly after a clock fall, never mid-high
    property p_oeEdge; $changed(sdaOe) |-> $past(!sclIn, 2); endproperty
    a_oeEdge: assert property (p_oeEdge) else $error("drive changed in clock high");
    property p_stopRel; sclIn && $rose(sdaIn) |=> !sdaOe [*4]; endproperty
    a_stopRel: assert property (p_stopRel) else $error("drive after stop");
    property p_odOnly; sdaOut == 1'b0; endproperty
    a_odOnly: assert property (p_odOnly) else $error("data driven high");
    property p_prio; (outputInternalRequest & ~request_priority_bit) == 4'h0; endproperty
    a_prio: assert property (p_prio) else $error("request passed low priority");
    property p_rstPin; !resetPin_b [*6] |-> (outputInternalRequest & 4'h9) == (request_priority_bit & 4'h9); endproperty
    a_rstPin: assert property (p_rstPin) else $error("reset pin did not force");
    // Long clock-high stretch means no byte can complete
    property p_polHold; sclIn [*8] |-> $stable(requestPolarity); endproperty
    a_polHold: assert property (p_polHold) else $error("polarity moved on idle bus");
    property p_reqHold; (sclIn && resetPin_b && $stable(request_priority_bit)) [*8] |-> $stable(outputInternalRequest);
    endproperty
    a_reqHold: assert property (p_reqHold) else $error("request moved on idle bus");
    property p_dec; {requestInMasterDecode, master_request_type_hi, master_request_type_lo} == 6'h3C; endproperty
    a_dec: assert property (p_dec) else $error("decode or type changed");
    property p_rstDef; $rose(rst_b) |-> requestPolarity == 4'hF && outputInternalRequest == (request_priority_bit & 4'h9);
    endproperty
    a_rstDef: assert property (p_rstDef) else $error("bad power-up defaults");
    c_ack: cover property ($rose(sdaOe));
    c_pin: cover property (!resetPin_b [*6]);
    c_rst: cover property ($rose(rst_b));
endmodule
bind cbi_config_slave cbi_config_slave_sva u_sva (.core_clk(core_clk), .rst_b(rst_b), .resetPin_b(resetPin_b),
    .sclIn(sclIn), .sdaIn(sdaIn), .sdaOut(sdaOut), .sdaOe(sdaOe), .address_select_pin(address_select_pin),
    .request_priority_bit(request_priority_bit), .outputInternalRequest(outputInternalRequest),
    .requestPolarity(requestPolarity), .requestInMasterDecode(requestInMasterDecode),
    .master_request_type_hi(master_request_type_hi), .master_request_type_lo(master_request_type_lo));
`default_nettype wire

//--- bench/cbi_config_slave_tb.sv
// Self-checking bench for the serial configuration slave
`default_nettype none
module cbi_config_slave_tb;
    timeunit 1ns;
    timeprecision 100ps;
    logic core_clk, rst_b, resetPin_b, asel, sdaOut, sdaOe, typeHi, typeLo, scl, sdaLow, sdaBus;
    logic [3:0] prio, oir, pol, dec;
    logic [7:0] rx, cur, d;
    int seed = 32'h18DA;
    int error_cnt = 0;
    int tests_run = 0;
    // Open-drain data line with pull-up
    assign sdaBus = ~(sdaLow | (sdaOe & ~sdaOut));
    cbi_config_slave u_dut (.core_clk(core_clk), .rst_b(rst_b), .resetPin_b(resetPin_b), .sclIn(scl),
        .sdaIn(sdaBus), .sdaOut(sdaOut), .sdaOe(sdaOe), .address_select_pin(asel), .request_priority_bit(prio),
        .outputInternalRequest(oir), .requestPolarity(pol), .requestInMasterDecode(dec),
        .master_request_type_hi(typeHi), .master_request_type_lo(typeLo));
    cbi_i2c_master u_mst (.scl(scl), .sdaLow(sdaLow), .sda(sdaBus));
    // 200 MHz core clock
    initial begin
        core_clk = 1'b0;
        forever #2.5 core_clk = ~core_clk;
    end
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        tests_run++;
        if (seen !== exp) begin
            error_cnt++;
            $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic print_verdict();
        $display("Checks %0d, mismatches %0d", tests_run, error_cnt);
        if (error_cnt == 0 && tests_run > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    // Expected outputs: gated internal requests over polarity
    function automatic logic [7:0] regView(input logic [7:0] r);
        return {r[7:4] & prio, r[3:0]};
    endfunction
    // One single-byte transfer; a read releases data and nacks
    task automatic txn(input logic [6:0] adr, input logic rd, input logic [7:0] wd, output logic a0, output logic a1);
        u_mst.start();
        u_mst.xfer({adr, rd}, rx, a0);
        u_mst.xfer(rd ? 8'hFF : wd, rx, a1);
        u_mst.stop();
        repeat (8) @(posedge core_clk);
    endtask
    initial begin
        logic a0, a1;
        rst_b = 1'b0;
        resetPin_b = 1'b1;
        asel = 1'b0;
        prio = 4'hF;
        repeat (8) @(posedge core_clk);
        rst_b <= 1'b1;
        repeat (4) @(posedge core_clk);
        chk({oir, pol}, regView(8'h9F));
        chk({dec, typeHi, typeLo, 2'b00}, 8'hF0);
        // Write, read back, then a foreign address; corners first
        for (int i = 0; i < 8; i++) begin
            d = (i == 0) ? 8'h00 : (i == 1) ? 8'hFF : 8'($random(seed));
            prio <= 4'($random(seed));
            asel <= i[0];
            @(posedge core_clk);
            txn({6'h36, asel}, 1'b0, d, a0, a1);
            chk({6'h00, a0, a1}, 8'h03);
            cur = d;
            chk({oir, pol}, regView(cur));
            txn({6'h36, asel}, 1'b1, 8'h00, a0, a1);
            chk(rx, cur);
            txn({6'h36, ~asel}, 1'b0, ~d, a0, a1);
            chk({6'h00, a0, a1}, 8'h00);
            chk({oir, pol}, regView(cur));
        end
        // A second data byte in one transfer is refused
        u_mst.start();
        u_mst.xfer({6'h36, asel, 1'b0}, rx, a0);
        u_mst.xfer(8'h5A, rx, a0);
        u_mst.xfer(8'hA5, rx, a1);
        u_mst.stop();
        repeat (8) @(posedge core_clk);
        chk({6'h00, a0, a1}, 8'h02);
        cur = 8'h5A;
        chk({oir, pol}, regView(cur));
        // Reset pin forces requests 4 and 1 and keeps the rest
        resetPin_b <= 1'b0;
        repeat (10) @(posedge core_clk);
        resetPin_b <= 1'b1;
        repeat (4) @(posedge core_clk);
        chk({oir, pol}, regView(cur | 8'h90));
        chk({dec, typeHi, typeLo, 2'h0}, 8'hF0);
        chk({7'h00, sdaOut}, 8'h00);
        // Power-up reset in mid-run brings the defaults back
        rst_b <= 1'b0;
        repeat (2) @(posedge core_clk);
        rst_b <= 1'b1;
        repeat (4) @(posedge core_clk);
        chk({oir, pol}, regView(8'h9F));
        print_verdict();
    end
    // Hang guard
    initial begin
        #400000;
        error_cnt++;
        print_verdict();
    end
endmodule
`default_nettype wire
